// *** src/serdes_transmit_path.sv ***
// Transmit path: capture, 8b/10b encode, PRBS test, serializer.
`timescale 1ns/1ps
`include "serdes_tx_defines.svh"
module serdes_transmit_path import serdes_tx_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Parallel side from the protocol device
  input wire logic i_ref_word_clock,
  input wire tx_word_t i_tx_word,
  // Test and mode controls
  input wire logic i_prbs_test_enable,
  input wire logic i_loopback_enable,
  // Serial side
  output serial_pair_t o_serial,
  output logic o_bit_clock
);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic clk_s1_ff;
  logic clk_s2_ff;
  logic clk_s3_ff;
  tx_word_t word_s1_ff;
  tx_word_t word_s2_ff;
  tx_word_t word_s3_ff;
  logic prbs_s1_ff;
  logic prbs_s2_ff;
  logic loop_s1_ff;
  logic loop_s2_ff;
  logic word_edge_w;

  // Each pin passes two flops; the word gets a third so that the value
  // taken is the one seen before the clock rise, not the next word.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      clk_s3_ff <= 1'b0;
      word_s1_ff <= '0;
      word_s2_ff <= '0;
      word_s3_ff <= '0;
    end else begin
      clk_s1_ff <= i_ref_word_clock;
      clk_s2_ff <= clk_s1_ff;
      clk_s3_ff <= clk_s2_ff;
      word_s1_ff <= i_tx_word; // [RQ2]
      word_s2_ff <= word_s1_ff;
      word_s3_ff <= word_s2_ff;
    end
  end

  // Mode pins are levels and only need the two-flop chain.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prbs_s1_ff <= 1'b0;
      prbs_s2_ff <= 1'b0;
      // Loopback resets high so the outputs stay floated until the pin's
      // real level has passed the chain. [RQ12] [RQ13]
      loop_s1_ff <= 1'b1;
      loop_s2_ff <= 1'b1;
    end else begin
      prbs_s1_ff <= i_prbs_test_enable;
      prbs_s2_ff <= prbs_s1_ff;
      loop_s1_ff <= i_loopback_enable;
      loop_s2_ff <= loop_s1_ff;
    end
  end

  // Rising edge of the word clock, seen past the synchroniser.
  assign word_edge_w = clk_s2_ff & ~clk_s3_ff; // [RQ1]

  // ==========================================================
  // Capture and PRBS source
  // ==========================================================
  tx_word_t cap_ff;
  logic cap_valid_ff;
  logic [15:0] prbs_word;

  // The generator steps once per word so the pattern is continuous.
  prbs7_gen #(
    .WIDTH(`WORD_BITS)
  ) u_prbs (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_step(word_edge_w & prbs_s2_ff),
    .o_word(prbs_word)
  );

  // One word per word clock rise; in test mode the pins are ignored.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cap_ff <= '0;
      cap_valid_ff <= 1'b0;
    end else begin
      cap_valid_ff <= word_edge_w;
      if (word_edge_w) begin
        if (prbs_s2_ff) begin
          cap_ff <= '{1'b0, 1'b0, prbs_word}; // [RQ10] [RQ11]
        end else begin
          cap_ff <= word_s3_ff; // [RQ1]
        end
      end
    end
  end

  // ==========================================================
  // Encoders and disparity chain
  // ==========================================================
  logic [9:0] code_low;
  logic [9:0] code_high;
  logic rd_low;
  logic rd_high;
  logic rd_ff;
  logic [19:0] enc_ff;

  // The low byte sees the carried disparity, the high byte sees the
  // low byte's result. [RQ7] [RQ16]
  enc_8b10b u_enc_low (
    .i_byte(cap_ff.data[7:0]),
    .i_kchar(cap_ff.low_byte_kchar_flag),
    .i_rd_pos(rd_ff),
    .o_code(code_low),
    .o_rd_pos(rd_low)
  );

  enc_8b10b u_enc_high (
    .i_byte(cap_ff.data[15:8]),
    .i_kchar(cap_ff.high_byte_kchar_flag),
    .i_rd_pos(rd_low),
    .o_code(code_high),
    .o_rd_pos(rd_high)
  );

  // Encoded word registered once per captured word.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      enc_ff <= '0;
      rd_ff <= `RD_RESET;
    end else if (cap_valid_ff) begin
      enc_ff <= {code_high, code_low}; // [RQ14] [RQ5]
      rd_ff <= rd_high; // [RQ16]
    end
  end

  // ==========================================================
  // Bit clock and word phase
  // ==========================================================
  logic [4:0] phase_ff;
  logic bit_clk_ff;
  logic load_w;
  logic [19:0] pend_ff;

  // i_clk runs at the bit edge rate; the bit clock is half of it, so
  // each of its edges carries one serial bit. [RQ3] [RQ4]
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bit_clk_ff <= 1'b0;
    end else begin
      bit_clk_ff <= ~bit_clk_ff; // [RQ3]
    end
  end

  // Phase realigns on every word edge, which keeps latency fixed while
  // the word clock keeps running. [RQ6] [RQ15]
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      phase_ff <= 5'h00;
    end else if (word_edge_w) begin
      phase_ff <= 5'h00;
    end else if (phase_ff == `PHASE_LAST) begin
      phase_ff <= 5'h00; // [RQ3]
    end else begin
      phase_ff <= phase_ff + 5'h01;
    end
  end

  // The previous word moves to the pending slot on each edge; this
  // extra word of delay brings the latency inside its window. [RQ6]
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pend_ff <= '0;
    end else if (word_edge_w) begin
      pend_ff <= enc_ff;
    end
  end

  assign load_w = (phase_ff == `LOAD_PHASE);

  // ==========================================================
  // Shift register and outputs
  // ==========================================================
  logic [19:0] sr_ff;
  logic ser_bit_ff;
  serial_pair_t ser_ff;

  // Twenty bits a word, bit zero of the pending word first.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sr_ff <= '0;
      ser_bit_ff <= 1'b0;
    end else if (load_w) begin
      sr_ff <= pend_ff >> 1; // [RQ14]
      ser_bit_ff <= pend_ff[0]; // [RQ5]
    end else begin
      sr_ff <= sr_ff >> 1; // [RQ4]
      ser_bit_ff <= sr_ff[0];
    end
  end

  // Outputs float in reset and during loopback. [RQ12] [RQ13]
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ser_ff <= '{1'b0, 1'b1, 1'b0}; // [RQ13]
    end else begin
      ser_ff.serial_out_pos <= ser_bit_ff;
      ser_ff.serial_out_neg <= ~ser_bit_ff;
      ser_ff.oe <= ~loop_s2_ff; // [RQ12]
    end
  end

  assign o_serial = ser_ff;
  assign o_bit_clock = bit_clk_ff;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_capture;
    word_edge_w && !prbs_s2_ff;
  endsequence

  sequence s_load_first_bit;
    load_w ##1 (ser_bit_ff == $past(pend_ff[0]));
  endsequence

  AST_CAPTURE_WORD: assert property ( // [RQ1]
    s_capture |=> cap_ff == $past(word_s3_ff))
    else $error("Word not captured on word clock rise.");

  AST_PRBS_REPLACES_WORD: assert property ( // [RQ11]
    (word_edge_w && prbs_s2_ff) |=>
      (cap_ff.data == $past(u_prbs.nxt_word)) &&
      !cap_ff.low_byte_kchar_flag && !cap_ff.high_byte_kchar_flag)
    else $error("PRBS pattern did not replace the parallel word.");

  AST_PHASE_WRAP: assert property ( // [RQ3]
    (phase_ff == `PHASE_LAST && !word_edge_w) |=> phase_ff == 5'h00)
    else $error("Word phase did not wrap after twenty bits.");

  AST_LOAD_AFTER_EDGE: assert property ( // [RQ6]
    word_edge_w ##1 (!word_edge_w)[*8] ##1 (!word_edge_w)[*3] |=> load_w)
    else $error("Serializer load not at fixed phase after word edge.");

  AST_FIRST_BIT: assert property ( // [RQ5]
    load_w |-> s_load_first_bit)
    else $error("Bit zero not sent first after load.");

  AST_SHIFT_ONE_PER_EDGE: assert property ( // [RQ4]
    !load_w |=> ser_bit_ff == $past(sr_ff[0]) && sr_ff[19] == 1'b0)
    else $error("Shift register did not advance one bit.");

  AST_DISPARITY_CHAIN: assert property ( // [RQ16]
    cap_valid_ff |=> rd_ff == $past(rd_high) &&
      enc_ff[9:0] == $past(code_low))
    else $error("Running disparity not carried between words.");

  AST_CODE_BALANCE: assert property ( // [RQ8]
    cap_valid_ff |-> ($countones(code_low) inside {4, 5, 6}) &&
      (($countones(code_low) != 5) == (rd_low != rd_ff)))
    else $error("Low character unbalanced or disparity wrong.");

  AST_K28_5_COMMA: assert property ( // [RQ9]
    (cap_valid_ff && cap_ff.low_byte_kchar_flag &&
     cap_ff.data[7:0] == 8'hBC) |->
      (code_low[6:0] == 7'h7C) || (code_low[6:0] == 7'h03))
    else $error("K flag did not select the comma character.");

  AST_LOOPBACK_FLOAT: assert property ( // [RQ12]
    loop_s2_ff |=> !o_serial.oe ##1 !$past(loop_s2_ff) || !o_serial.oe)
    else $error("Serial outputs driven during loopback.");

  AST_DIFF_PAIR: assert property ( // [RQ12]
    o_serial.oe |-> o_serial.serial_out_neg == ~o_serial.serial_out_pos)
    else $error("Serial pair not complementary.");

endmodule : serdes_transmit_path

// *** include/serdes_tx_defines.svh ***
// Constants for the serial transmit path: widths, phases, seeds.
//
// Overview of operation
// [RQ1] Capture the 16-bit word and both K flags on every word clock rise.
// [RQ2] The protocol device keeps word and flags stable around each rise.
// [RQ3] An internal bit clock runs at ten times the word clock rate.
// [RQ4] One bit leaves on each bit clock edge, twenty bits per word.
// [RQ5] The code bits of parallel bit zero are sent first.
// [RQ6] Word load to first serial bit takes a fixed 34 to 38 bit times.
// [RQ7] The word is split into two bytes, each with its own encoder.
// [RQ8] Each encoder makes a 10-bit 8b/10b character with disparity.
// [RQ9] Each K flag selects K or D coding for its own byte.
// [RQ10] The test enable selects a period-127 seven-stage PRBS payload.
// [RQ11] In PRBS mode the parallel word is ignored and PRBS goes through.
// [RQ12] Serial outputs float while loopback is high, driven while low.
// [RQ13] Serial outputs float throughout power-on reset.
// [RQ14] The two 10-bit codes form one 20-bit word for the shifter.
// [RQ15] The outside word clock runs continuously between 80 and 135 MHz.
// [RQ16] Running disparity goes low byte to high byte to next low byte.
// [RQ17] The PRBS uses x^7 + x^6 + 1 and never reaches all zeros.
`ifndef SERDES_TX_DEFINES_SVH
`define SERDES_TX_DEFINES_SVH

// ==========================================================
// Widths
`define WORD_BITS 16
`define BYTE_BITS 8
`define CODE_BITS 10
`define SER_BITS 20
`define BIT_CLK_MULT 10

// ==========================================================
// Serializer phase and latency, in bit times (one i_clk each)
`define PHASE_LAST 5'h13
`define LOAD_PHASE 5'h0B
`define LAT_MIN_BITS 34
`define LAT_MAX_BITS 38

// ==========================================================
// Reset values
`define PRBS_SEED 7'h7F
`define RD_RESET 1'h0

`endif

// *** include/serdes_tx_pkg.sv ***
// Types shared by the serial transmit path.
package serdes_tx_pkg;

  // Parallel word with its two K-character flags.
  typedef struct packed {
    logic high_byte_kchar_flag;
    logic low_byte_kchar_flag;
    logic [15:0] data;
  } tx_word_t;

  // Differential serial output with its common output enable.
  typedef struct packed {
    logic serial_out_pos;
    logic serial_out_neg;
    logic oe;
  } serial_pair_t;

endpackage : serdes_tx_pkg

// *** src/enc_8b10b.sv ***
// One byte-wide 8b/10b encoder with running disparity in and out.
`timescale 1ns/1ps
module enc_8b10b import serdes_tx_pkg::*; (
  // Byte and control
  input wire logic [7:0] i_byte,
  input wire logic i_kchar,
  input wire logic i_rd_pos,
  // Character and new disparity
  output logic [9:0] o_code,
  output logic o_rd_pos
);

  // ==========================================================
  // Encoding, bit a of the character lands in o_code[0].
  always_comb begin
    logic [5:0] c6;
    logic [3:0] c4;
    logic [9:0] seq;
    logic k28;
    logic rd_mid;
    logic alt7;
    logic flip4;
    c6 = 6'h00;
    c4 = 4'h0;
    seq = 10'h000;
    k28 = i_kchar && (i_byte[4:0] == 5'h1C); // [RQ9]
    rd_mid = 1'b0;
    alt7 = 1'b0;
    flip4 = 1'b0;
    // Six-bit sub-block, listed for negative disparity. [RQ8]
    case (i_byte[4:0])
      5'h00: c6 = 6'h27;
      5'h01: c6 = 6'h1D;
      5'h02: c6 = 6'h2D;
      5'h03: c6 = 6'h31;
      5'h04: c6 = 6'h35;
      5'h05: c6 = 6'h29;
      5'h06: c6 = 6'h19;
      5'h07: c6 = 6'h38;
      5'h08: c6 = 6'h39;
      5'h09: c6 = 6'h25;
      5'h0A: c6 = 6'h15;
      5'h0B: c6 = 6'h34;
      5'h0C: c6 = 6'h0D;
      5'h0D: c6 = 6'h2C;
      5'h0E: c6 = 6'h1C;
      5'h0F: c6 = 6'h17;
      5'h10: c6 = 6'h1B;
      5'h11: c6 = 6'h23;
      5'h12: c6 = 6'h13;
      5'h13: c6 = 6'h32;
      5'h14: c6 = 6'h0B;
      5'h15: c6 = 6'h2A;
      5'h16: c6 = 6'h1A;
      5'h17: c6 = 6'h3A;
      5'h18: c6 = 6'h33;
      5'h19: c6 = 6'h26;
      5'h1A: c6 = 6'h16;
      5'h1B: c6 = 6'h36;
      5'h1C: c6 = 6'h0E;
      5'h1D: c6 = 6'h2E;
      5'h1E: c6 = 6'h1E;
      default: c6 = 6'h2B;
    endcase
    if (k28) begin
      c6 = 6'h0F;
    end
    // Unbalanced blocks and D.7 take the complement at positive disparity.
    if (i_rd_pos && (($countones(c6) != 3) || (c6 == 6'h38))) begin
      c6 = ~c6;
    end
    rd_mid = i_rd_pos ^ ($countones(c6) != 3);
    // The alternate x.7 avoids a run of five inside data characters.
    alt7 = i_kchar ||
           (!rd_mid && ((i_byte[4:0] == 5'h11) || (i_byte[4:0] == 5'h12) ||
                        (i_byte[4:0] == 5'h14))) ||
           (rd_mid && ((i_byte[4:0] == 5'h0B) || (i_byte[4:0] == 5'h0D) ||
                       (i_byte[4:0] == 5'h0E)));
    case (i_byte[7:5])
      3'h0: c4 = 4'hB;
      3'h1: c4 = 4'h9;
      3'h2: c4 = 4'h5;
      3'h3: c4 = 4'hC;
      3'h4: c4 = 4'hD;
      3'h5: c4 = 4'hA;
      3'h6: c4 = 4'h6;
      default: c4 = alt7 ? 4'h7 : 4'hE;
    endcase
    flip4 = ($countones(c4) != 2) || (c4 == 4'hC);
    if (rd_mid && flip4) begin
      c4 = ~c4;
    end else if (k28 && !rd_mid && !flip4) begin
      c4 = ~c4; // [RQ9]
    end
    o_rd_pos = rd_mid ^ ($countones(c4) != 2); // [RQ8]
    seq = {c6, c4};
    for (int i = 0; i < 10; i++) begin
      o_code[i] = seq[9 - i];
    end
  end

endmodule : enc_8b10b

// *** src/prbs7_gen.sv ***
// Seven-stage pseudorandom generator that yields a word per step.
`timescale 1ns/1ps
`include "serdes_tx_defines.svh"
module prbs7_gen import serdes_tx_pkg::*; #(
  parameter int WIDTH = `WORD_BITS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Control and pattern
  input wire logic i_step,
  output logic [WIDTH-1:0] o_word
);

  logic [6:0] state_ff;
  logic [6:0] nxt_state;
  logic [WIDTH-1:0] nxt_word;

  // ==========================================================
  // Run WIDTH shifts of x^7 + x^6 + 1, first bit into bit zero.
  always_comb begin
    logic [6:0] s;
    logic fb;
    s = state_ff;
    fb = 1'b0;
    nxt_word = '0;
    for (int i = 0; i < WIDTH; i++) begin
      fb = s[6] ^ s[5]; // [RQ17]
      s = {s[5:0], fb};
      nxt_word[i] = fb;
    end
    // A zero state would lock up, so it is reseeded.
    nxt_state = (s == 7'h00) ? `PRBS_SEED : s; // [RQ17]
    // The word shown is the one the next step yields, so a capture on the
    // stepping edge takes the fresh word and not a stale one.
    o_word = nxt_word;
  end

  // The state moves only when stepped.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= `PRBS_SEED;
    end else if (i_step) begin
      state_ff <= nxt_state; // [RQ10]
    end
  end

  AST_PRBS_NONZERO: assert property ( // [RQ17]
    @(posedge i_clk) disable iff (!i_nrst) state_ff != 7'h00)
    else $error("PRBS state reached all zeros.");

endmodule : prbs7_gen

// *** sim/tx_word_source.sv ***
// Protocol-device model that drives the word clock and parallel word.
`timescale 1ns/1ps
module tx_word_source import serdes_tx_pkg::*; (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_run,
  input wire tx_word_t i_word,
  // Parallel side toward the transmit path
  output logic o_ref_word_clock,
  output tx_word_t o_tx_word
);
  int cnt;

  // ==========================================================
  // Word clock and data
  initial begin
    cnt = 0;
    o_ref_word_clock = 1'b0;
    o_tx_word = '0;
  end

  // The word changes ten cycles before each rise and holds ten after.
  // When idle the word toggles, so stale data can never pass as valid.
  always @(negedge i_clk) begin
    if (!i_run) begin
      cnt <= 0;
      o_ref_word_clock <= 1'b0;
      o_tx_word <= ~o_tx_word;
    end else begin
      cnt <= (cnt == 19) ? 0 : cnt + 1;
      o_ref_word_clock <= (cnt >= 10);
      if (cnt == 0) begin
        o_tx_word <= i_word;
      end
    end
  end
endmodule : tx_word_source

// *** sim/serdes_transmit_path_tb_top.sv ***
// Self-checking bench for the serial transmit path.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  error_cnt++; $display("wrong value %s exp %h got %h", nm, e, g); \
  end end
module serdes_transmit_path_tb_top import serdes_tx_pkg::*; ;
  logic i_clk, i_nrst, i_prbs_test_enable, i_loopback_enable, run;
  logic wclk, bclk, wclk_prev, bclk_prev, e, g;
  tx_word_t pin_word, src_word, w;
  serial_pair_t ser;
  int error_cnt, tests_run, rd;
  logic [6:0] prbs;
  bit chk_on, prbs_on;
  logic cap[$];
  int rise_q[$];
  bit exp_q[$];
  localparam logic [5:0] T6 [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35,
    6'h29, 6'h19, 6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C,
    6'h17, 6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A, 6'h33,
    6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] T4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA,
    4'h6, 4'hE};
  localparam logic [7:0] KT [12] = '{8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C,
    8'hBC, 8'hDC, 8'hFC, 8'hF7, 8'hFB, 8'hFD, 8'hFE};

  serdes_transmit_path u_dut (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_ref_word_clock(wclk), .i_tx_word(pin_word),
    .i_prbs_test_enable(i_prbs_test_enable),
    .i_loopback_enable(i_loopback_enable), .o_serial(ser), .o_bit_clock(bclk));
  tx_word_source u_src (.i_clk(i_clk), .i_run(run), .i_word(src_word),
    .o_ref_word_clock(wclk), .o_tx_word(pin_word));

  // ==========================================================
  // Reference model
  // Encodes one byte, tracking disparity, and queues bits a to j.
  function automatic void enc(input logic [7:0] b, input logic k);
    logic [5:0] c6;
    logic [3:0] c4;
    int x;
    int y;
    bit alt;
    x = b[4:0];
    y = b[7:5];
    c6 = (k && x == 28) ? 6'h0F : T6[x];
    if (rd != 0 && ($countones(c6) != 3 || x == 7)) c6 = ~c6;
    if ($countones(c6) != 3) rd = 1 - rd;
    alt = (y == 7) && (k || (rd == 0 && (x == 17 || x == 18 || x == 20))
      || (rd == 1 && (x == 11 || x == 13 || x == 14)));
    c4 = alt ? 4'h7 : T4[y];
    // K28 after a negative six-bit block also flips its balanced tails, except y == 3.
    if (rd != 0 && ($countones(c4) != 2 || y == 3)) c4 = ~c4;
    else if (k && x == 28 && rd == 0 && $countones(c4) == 2 && y != 3)
      c4 = ~c4;
    if ($countones(c4) != 2) rd = 1 - rd;
    for (int i = 5; i >= 0; i--) exp_q.push_back(c6[i]);
    for (int i = 3; i >= 0; i--) exp_q.push_back(c4[i]);
  endfunction : enc

  // Sixteen pattern steps; the first new bit lands in data bit zero.
  function automatic logic [15:0] prbs_word();
    logic [15:0] pw;
    logic n;
    for (int i = 0; i < 16; i++) begin
      n = prbs[6] ^ prbs[5];
      prbs = {prbs[5:0], n};
      pw[i] = n;
    end
    return pw;
  endfunction : prbs_word

  // The first four words walk all flag pairs, then flags are random.
  function automatic tx_word_t rnd_word(input int idx);
    tx_word_t rw;
    rw.data = $urandom;
    rw.low_byte_kchar_flag = (idx < 4) ? idx[0] : $urandom;
    rw.high_byte_kchar_flag = (idx < 4) ? idx[1] : $urandom;
    if (rw.low_byte_kchar_flag) rw.data[7:0] = KT[$urandom % 12];
    if (rw.high_byte_kchar_flag) rw.data[15:8] = KT[$urandom % 12];
    return rw;
  endfunction : rnd_word

  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // ==========================================================
  // Clock, monitor and watchdog
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Samples before the edge updates land, so each bit is seen settled.
  always @(posedge i_clk) begin
    cap.push_back(ser.serial_out_pos);
    if (chk_on) begin
      `CHK("oe", 1'b1, ser.oe)
      `CHK("neg", ~ser.serial_out_pos, ser.serial_out_neg)
      `CHK("bit clock", ~bclk_prev, bclk)
    end
    bclk_prev = bclk;
    if (wclk && !wclk_prev) begin
      rise_q.push_back(cap.size() - 1);
      w = prbs_on ? tx_word_t'({2'b00, prbs_word()}) : pin_word;
      enc(w.data[7:0], w.low_byte_kchar_flag);
      enc(w.data[15:8], w.high_byte_kchar_flag);
      src_word = rnd_word(rise_q.size());
    end
    wclk_prev = wclk;
  end

  // Both phases need about 1020 cycles; this leaves a wide margin.
  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    finish_test();
  end

  // ==========================================================
  // Scenarios
  // Resets, streams n words and lines the stream up with the model.
  // The offset counts one extra cycle for the sampling edge.
  task automatic run_words(input bit prbs_mode, input int n);
    int d;
    bit ok;
    bit found;
    i_nrst = 1'b0;
    i_prbs_test_enable = prbs_mode;
    repeat (20) @(negedge i_clk);
    `CHK("oe in reset", 1'b0, ser.oe)
    i_loopback_enable = 1'b0;
    cap.delete();
    rise_q.delete();
    exp_q.delete();
    rd = 0;
    prbs = 7'h7F;
    prbs_on = prbs_mode;
    src_word = rnd_word(0);
    i_nrst = 1'b1;
    repeat (4) @(negedge i_clk);
    chk_on = 1'b1;
    run <= 1'b1;
    repeat (20 * n) @(negedge i_clk);
    run <= 1'b0;
    repeat (80) @(negedge i_clk);
    chk_on = 1'b0;
    d = 36;
    found = 1'b0;
    for (int t = 39; t >= 35; t--) begin
      ok = 1'b1;
      for (int i = 0; i < 20; i++) begin
        if (cap[rise_q[0] + t + i] !== exp_q[i]) ok = 1'b0;
      end
      if (ok) begin
        d = t;
        found = 1'b1;
      end
    end
    `CHK("latency", 1'b1, found)
    // The last word leaves only on the next rise, which never comes.
    for (int k = 0; k < rise_q.size() - 1; k++) begin
      for (int i = 0; i < 20; i++) begin
        e = exp_q[20 * k + i];
        g = cap[rise_q[k] + d + i];
        `CHK("serial bit", e, g)
        // Same stream check also covers
      end
    end
  endtask : run_words

  initial begin
    i_nrst = 1'b0;
    i_prbs_test_enable = 1'b0;
    i_loopback_enable = 1'b1;
    run = 1'b0;
    chk_on = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    wclk_prev = 1'b0;
    bclk_prev = 1'b0;
    src_word = '0;
    void'($urandom(32'h1E2A));
    @(negedge i_clk);
    run_words(1'b0, 24);
    i_loopback_enable = 1'b1;
    repeat (5) @(negedge i_clk);
    `CHK("oe loopback", 1'b0, ser.oe)
    i_loopback_enable = 1'b0;
    repeat (5) @(negedge i_clk);
    `CHK("oe active", 1'b1, ser.oe)
    run_words(1'b1, 16);
    finish_test();
  end
endmodule : serdes_transmit_path_tb_top
